// ### core/ccks_regs.sv
// capacity and key status registers behind an APB slave
// assumes fuse data is stable from reset and the upgrade block reports its key check
//
// How it works
// - secret key read over four words, lowest sixteen bits first
// - fourth key word carries bits 55:48 in its low byte only
// - class field: zero means 128 upgradable, one to four fixed, rest reserved
// - fused count field encodes channels as value plus one times eight
// - status word reports key check and current count, upper bits zero
// - upgrade-in-use bit set while upgraded count is in force
// - key-valid bit set when the loaded upgrade key is accepted
// - current count field uses the same eight-channel steps
// - current count starts from the fused count, not a constant
`timescale 1ns/1ns
`default_nettype none
`include "ccks_params.svh"

module ccks_regs #(
    parameter int FUSE_LOAD_CYCLES = `CCKS_FUSE_LOAD_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // fuse array
    input wire ccks_pkg::ccks_fuse_t fuse_in,
    // upgrade request and key check result
    input wire ccks_pkg::ccks_upgrade_t upgrade_in,
    // capacity in force for the channel logic
    output logic [3:0] current_channel_count,
    output logic upgrade_in_use
);
    import ccks_pkg::*;

    // ************************************************************
    // start-up fuse load
    // ************************************************************
    ccks_state_t state_q;
    logic [3:0] load_cnt_q;
    ccks_fuse_t fuse_q;
    logic loaded;

    assign loaded = (state_q == CCKS_READY);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_cnt_q <= 4'h0;
        end else if (!loaded) begin
            load_cnt_q <= load_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= CCKS_LOADING;
        end else begin
            unique case (state_q)
                CCKS_LOADING: begin
                    if (load_cnt_q == 4'(FUSE_LOAD_CYCLES - 1)) begin
                        state_q <= CCKS_READY;
                    end
                end
                CCKS_READY: begin
                    state_q <= CCKS_READY;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_q.secret_key_bits <= `CCKS_KEY_RESET;
            fuse_q.capacity_class <= `CCKS_CLASS_RESET;
            fuse_q.fused_channel_count <= `CCKS_COUNT_RESET;
        end else if (!loaded) begin
            fuse_q <= fuse_in;
        end
    end

    // ************************************************************
    // capacity selection
    // ************************************************************
    logic match_q;
    logic comp_q;
    logic [3:0] cur_q;
    logic upgradable;
    logic grant;

    assign upgradable = (fuse_q.capacity_class == `CCKS_CLASS_UPGRADABLE);
    assign grant = upgrade_in.key_check_pass && upgradable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_q <= 1'b0;
        end else begin
            match_q <= loaded && upgrade_in.key_check_pass;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_q <= 1'b0;
        end else begin
            comp_q <= loaded && grant;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_q <= `CCKS_COUNT_RESET;
        end else if (!loaded) begin
            cur_q <= fuse_in.fused_channel_count;
        end else if (grant) begin
            cur_q <= upgrade_in.requested_channel_count;
        end else begin
            cur_q <= fuse_q.fused_channel_count;
        end
    end

    assign current_channel_count = cur_q;
    assign upgrade_in_use = comp_q;

    // ************************************************************
    // apb read mux
    // ************************************************************
    logic [11:0] idx;
    logic [31:0] rd_d;
    logic hit;
    logic [31:0] prdata_q;
    logic err_q;

    assign idx = paddr[13:2];

    always_comb begin
        rd_d = 32'h0000_0000;
        hit = 1'b1;
        unique case (idx)
            `CCKS_IDX_KEY_W0: rd_d[15:0] = fuse_q.secret_key_bits[15:0];
            `CCKS_IDX_KEY_W1: rd_d[15:0] = fuse_q.secret_key_bits[31:16];
            `CCKS_IDX_KEY_W2: rd_d[15:0] = fuse_q.secret_key_bits[47:32];
            `CCKS_IDX_KEY_W3: rd_d[7:0] = fuse_q.secret_key_bits[55:48];
            `CCKS_IDX_FUSED_CAPACITY_CLASS: begin
                rd_d[`CCKS_FLD_CLASS_LSB +: 4] = fuse_q.capacity_class;
                rd_d[`CCKS_FLD_COUNT_LSB +: 4] = fuse_q.fused_channel_count;
            end
            `CCKS_IDX_LICENSE: begin
                rd_d[`CCKS_FLD_COMP_BIT] = comp_q;
                rd_d[`CCKS_FLD_MATCH_BIT] = match_q;
                rd_d[`CCKS_FLD_COUNT_LSB +: 4] = cur_q;
            end
            default: hit = 1'b0;
        endcase
    end

    // data sampled in setup phase, answered in access phase
    // refreshed while answers are held back
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && (!penable || !loaded)) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
        end
    end

    // writes and unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q <= 1'b0;
        end else if (psel && (!penable || !loaded)) begin
            err_q <= pwrite || !hit;
        end
    end

    assign pready = loaded;
    assign prdata = prdata_q;
    assign pslverr = psel && penable && loaded && err_q;

    // ************************************************************
    // checks
    // ************************************************************
    logic rd_done;
    logic [4:0] rst_age_q;
    assign rd_done = psel && penable && pready && !pwrite;

    // edges seen since reset release, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_age_q <= 5'h00;
        end else if (rst_age_q != 5'h1F) begin
            rst_age_q <= rst_age_q + 5'h01;
        end
    end

    chk_key_word0: assert property (@(posedge pclk) disable iff (!presetn)
        rd_done && $stable(paddr) && idx == `CCKS_IDX_KEY_W0
        |-> prdata[15:0] == fuse_q.secret_key_bits[15:0] && prdata[31:16] == 16'h0000)
        else $error("key word 0 read mismatch");

    chk_key_top_byte: assert property (@(posedge pclk) disable iff (!presetn)
        rd_done && idx == `CCKS_IDX_KEY_W3
        |-> prdata[31:8] == 24'h00_0000 && prdata[7:0] == fuse_q.secret_key_bits[55:48])
        else $error("key word 3 upper byte not zero");

    chk_class_gate: assert property (@(posedge pclk) disable iff (!presetn)
        comp_q |-> $past(fuse_q.capacity_class) == `CCKS_CLASS_UPGRADABLE)
        else $error("upgrade granted to fixed class");

    chk_capacity_class_pack: assert property (@(posedge pclk) disable iff (!presetn)
        rd_done && idx == `CCKS_IDX_FUSED_CAPACITY_CLASS
        |-> prdata == {24'h00_0000, fuse_q.capacity_class, fuse_q.fused_channel_count})
        else $error("fused capacity_class layout wrong");

    chk_status_upper: assert property (@(posedge pclk) disable iff (!presetn)
        rd_done && idx == `CCKS_IDX_LICENSE |-> prdata[31:6] == 26'h000_0000)
        else $error("status upper bits not zero");

    chk_inuse_set: assert property (@(posedge pclk) disable iff (!presetn)
        loaded && grant |=> comp_q && cur_q == $past(upgrade_in.requested_channel_count))
        else $error("upgrade not taken into use");

    chk_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
        loaded |=> match_q == $past(upgrade_in.key_check_pass))
        else $error("key valid flag wrong");

    chk_count_start: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(loaded) |-> cur_q == fuse_q.fused_channel_count ##1 1'b1)
        else $error("current count not fused count after load");

    chk_count_fallback: assert property (@(posedge pclk) disable iff (!presetn)
        loaded && !grant |=> !comp_q && cur_q == fuse_q.fused_channel_count)
        else $error("current count not fused count without grant");

    chk_load_hold: assert property (@(posedge pclk) disable iff (!presetn)
        rst_age_q < 5'(FUSE_LOAD_CYCLES) |-> !pready)
        else $error("answer before fuses loaded");

    chk_load_release: assert property (@(posedge pclk) disable iff (!presetn)
        rst_age_q >= 5'(FUSE_LOAD_CYCLES) |-> pready)
        else $error("answers still held after fuse load");

    chk_ready_held: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> pready)
        else $error("ready dropped after fuse load");

    chk_key_word1: assert property (@(posedge pclk) disable iff (!presetn)
        rd_done && idx == `CCKS_IDX_KEY_W1
        |-> prdata == {16'h0000, fuse_q.secret_key_bits[31:16]})
        else $error("key word 1 read mismatch");

    chk_key_word2: assert property (@(posedge pclk) disable iff (!presetn)
        rd_done && idx == `CCKS_IDX_KEY_W2
        |-> prdata == {16'h0000, fuse_q.secret_key_bits[47:32]})
        else $error("key word 2 read mismatch");

    chk_status_count: assert property (@(posedge pclk) disable iff (!presetn)
        rd_done && idx == `CCKS_IDX_LICENSE
        |-> prdata[3:0] == $past(current_channel_count))
        else $error("status count not the count in force");

    chk_write_refused: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite |-> pslverr)
        else $error("write to read-only register not refused");

    chk_fixed_count: assert property (@(posedge pclk) disable iff (!presetn)
        loaded && !upgradable |=> cur_q == fuse_q.fused_channel_count)
        else $error("fixed class count left the fused count");

    chk_fixed_inuse: assert property (@(posedge pclk) disable iff (!presetn)
        loaded && !upgradable |=> !comp_q)
        else $error("fixed class shows upgrade in use");

    cov_status_read: cover property (@(posedge pclk) disable iff (!presetn)
        rd_done && idx == `CCKS_IDX_LICENSE);
    cov_upgrade_on: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(comp_q));
    cov_error_answer: cover property (@(posedge pclk) disable iff (!presetn)
        pslverr);
    cov_fixed_refused: cover property (@(posedge pclk) disable iff (!presetn)
        loaded && upgrade_in.key_check_pass && !upgradable);
    cov_load_wait: cover property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready);

endmodule

`default_nettype wire

// ### core/ccks_params.svh
// constants of the capacity and key status register group
// assumes byte addresses are four times the register index
`ifndef CCKS_PARAMS_SVH
`define CCKS_PARAMS_SVH

// register indices
`define CCKS_IDX_KEY_W0 12'h010
`define CCKS_IDX_KEY_W1 12'h011
`define CCKS_IDX_KEY_W2 12'h012
`define CCKS_IDX_KEY_W3 12'h013
`define CCKS_IDX_FUSED_CAPACITY_CLASS 12'h014
`define CCKS_IDX_LICENSE 12'hA98

// field positions
`define CCKS_FLD_COUNT_LSB 0
`define CCKS_FLD_CLASS_LSB 4
`define CCKS_FLD_MATCH_BIT 4
`define CCKS_FLD_COMP_BIT 5

// encodings and reset values
`define CCKS_CLASS_UPGRADABLE 4'h0
`define CCKS_COUNT_RESET 4'h0
`define CCKS_CLASS_RESET 4'h0
`define CCKS_KEY_RESET 56'h00_0000_0000_0000

// cycles spent fetching fuses after reset release
`define CCKS_FUSE_LOAD_CYCLES 4

`endif

// ### core/ccks_pkg.sv
// types of the capacity and key status register group
// assumes ccks_params.svh supplies the numbers
`default_nettype none

package ccks_pkg;

    // fused contents read at start-up
    typedef struct packed {
        logic [55:0] secret_key_bits;
        logic [3:0] capacity_class;
        logic [3:0] fused_channel_count;
    } ccks_fuse_t;

    // upgrade request from the writable upgrade registers
    typedef struct packed {
        logic key_check_pass;
        logic [3:0] requested_channel_count;
    } ccks_upgrade_t;

    typedef enum logic {
        CCKS_LOADING = 1'b0,
        CCKS_READY = 1'b1
    } ccks_state_t;

endpackage

`default_nettype wire

// ### sim/ccks_regs_tb.sv
// self-checking bench of the capacity and key status registers
// assumes ccks_regs with zero wait states once fuses are loaded
`timescale 1ns/1ns
`default_nettype none
`include "ccks_params.svh"

module ccks_regs_tb;
    import ccks_pkg::*;

    localparam int LOAD = 4;
    localparam logic [55:0] KEY = 56'hA5_1234_5678_9ABC;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, upgrade_in_use;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb, current_channel_count;
    ccks_fuse_t fuse_in;
    ccks_upgrade_t upgrade_in;
    int err_count, total_checks;

    ccks_regs #(.FUSE_LOAD_CYCLES(LOAD)) ccks_regs_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fuse_in(fuse_in),
        .upgrade_in(upgrade_in), .current_channel_count(current_channel_count),
        .upgrade_in_use(upgrade_in_use)
    );

    always #50 pclk = ~pclk;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, answer taken at the pready edge
    task automatic apb(input logic wr, input logic [11:0] idx, output logic [31:0] d,
                       output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= 32'h0000_FFFF;
        @(posedge pclk);
        penable <= 1'b1;
        // request held until an edge sees pready high
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic e;
        apb(1'b0, idx, d, e);
        chk(d, exp);
        chk({31'h0, e}, 32'h0);
    endtask

    function automatic logic [31:0] st(input logic c, input logic m, input logic [3:0] n);
        st = 32'h0;
        st[`CCKS_FLD_COMP_BIT] = c;
        st[`CCKS_FLD_MATCH_BIT] = m;
        st[3:0] = n;
    endfunction

    task automatic do_reset(input logic [3:0] cls, input logic [3:0] cnt,
                            input logic pass, input logic [3:0] req);
        presetn <= 1'b0;
        fuse_in <= {KEY, cls, cnt};
        upgrade_in <= {pass, req};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_fuse_load();
        do_reset(4'h0, 4'h3, 1'b0, 4'h9);
        @(negedge pclk);
        // answer held back while fuses load
        chk({31'h0, pready}, 32'h0);
        rd(`CCKS_IDX_KEY_W0, 32'h0000_9ABC);
        rd(`CCKS_IDX_KEY_W1, 32'h0000_5678);
        rd(`CCKS_IDX_KEY_W2, 32'h0000_1234);
        rd(`CCKS_IDX_KEY_W3, 32'h0000_00A5);
        rd(`CCKS_IDX_FUSED_CAPACITY_CLASS, 32'h0000_0003);
        rd(`CCKS_IDX_LICENSE, st(1'b0, 1'b0, 4'h3));
        chk({28'h0, current_channel_count}, 32'h3);
        $display("test fuse_load done");
    endtask

    task automatic t_upgrade();
        upgrade_in <= {1'b1, 4'hE};
        repeat (2) @(posedge pclk);
        rd(`CCKS_IDX_LICENSE, st(1'b1, 1'b1, 4'hE));
        chk({27'h0, upgrade_in_use, current_channel_count}, 32'h1E);
        upgrade_in <= {1'b1, 4'hF};
        repeat (2) @(posedge pclk);
        rd(`CCKS_IDX_LICENSE, st(1'b1, 1'b1, 4'hF));
        upgrade_in <= {1'b0, 4'hF};
        repeat (2) @(posedge pclk);
        rd(`CCKS_IDX_LICENSE, st(1'b0, 1'b0, 4'h3));
        chk({27'h0, upgrade_in_use, current_channel_count}, 32'h03);
        $display("test upgrade done");
    endtask

    task automatic t_fixed_class();
        for (int c = 1; c <= 5; c++) begin
            do_reset(c[3:0], 4'h2, 1'b1, 4'hF);
            rd(`CCKS_IDX_FUSED_CAPACITY_CLASS, {24'h0, c[3:0], 4'h2});
            rd(`CCKS_IDX_LICENSE, st(1'b0, 1'b1, 4'h2));
            chk({27'h0, upgrade_in_use, current_channel_count}, 32'h02);
        end
        $display("test fixed_class done");
    endtask

    task automatic t_refused();
        logic [31:0] d;
        logic e;
        do_reset(4'h0, 4'hF, 1'b0, 4'h0);
        apb(1'b1, `CCKS_IDX_LICENSE, d, e);
        chk({31'h0, e}, 32'h1);
        rd(`CCKS_IDX_LICENSE, st(1'b0, 1'b0, 4'hF));
        apb(1'b0, 12'h020, d, e);
        chk({31'h0, e}, 32'h1);
        chk(d, 32'h0);
        $display("test refused done");
    endtask

    // ****************************************
    // run control
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 14'h0000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        fuse_in = '0;
        upgrade_in = '0;
        err_count = 0;
        total_checks = 0;
        t_fuse_load();
        t_upgrade();
        t_fixed_class();
        t_refused();
        print_verdict();
    end

    initial begin
        #(100 * 5000);
        err_count++;
        print_verdict();
    end

endmodule

`default_nettype wire
